// ---- hdl/aes_defines.svh ----
// constants for the eight channel converter scanner
`ifndef AES_DEFINES_SVH
`define AES_DEFINES_SVH
`define AES_RS_DATA_A       2'h0
`define AES_RS_CTRL_A       2'h1
`define AES_RS_DATA_B       2'h2
`define AES_RS_CTRL_B       2'h3
`define AES_CTRL_SEL_BIT    2
`define AES_CTRL_RST        8'h00
`define AES_DDR_RST         8'h00
`define AES_DIR_ALL_OUT     8'hFF
`define AES_DIR_ALL_IN      8'h00
`define AES_PTR_START       4'h1
`define AES_RES_BASE        8'h10
`define AES_OVR_CODE        8'hF1
`define AES_OVR_MASK        4'hB
`define AES_OVR_MATCH       4'h3
`define AES_FIRST_WAITS     2'h3
`define AES_LATER_WAITS     2'h2
`define AES_NUM_CH          8
`define AES_SCAN_MS         320
`define AES_CONV_KHZ        400
`define AES_CLK_MHZ         25
`endif

// ---- hdl/aes_pkg.sv ----
// types for the eight channel converter scanner
package aes_pkg;
	typedef enum logic [5:0] {
		AES_IDLE  = 6'h01,
		AES_ARM   = 6'h02,
		AES_WAIT  = 6'h04,
		AES_DIGIT = 6'h08,
		AES_FIX   = 6'h10,
		AES_NEXT  = 6'h20
	} aes_state_e;
	typedef logic [7:0] aes_byte_t;
endpackage

// ---- hdl/aes_res_if.sv ----
// result write channel between scanner and result store
`timescale 1ns/100ps
interface aes_res_if;
	logic       wr;
	logic [7:0] addr;
	logic [7:0] data;
	modport src (output wr, output addr, output data);
	modport dst (input  wr, input  addr, input  data);
endinterface

// ---- hdl/aes_sync3.sv ----
// three flop input synchroniser with agreement filter
`timescale 1ns/100ps
module aes_sync3 #(
	parameter int W = 8
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_b,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1     <= '0;
			s2     <= '0;
			s3     <= '0;
			o_sync <= '0;
		end else begin
			s1 <= i_async;
			s2 <= s1;
			s3 <= s2;
			// change counts once stages two and three agree
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					o_sync[i] <= s2[i];
				end
			end
		end
	end
endmodule

// ---- hdl/aes_store.sv ----
// result word store written by the scanner, read by address
`timescale 1ns/100ps
`include "aes_defines.svh"
module aes_store #(
	parameter int DEPTH = 4 * `AES_NUM_CH
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_b,
	aes_res_if.dst            res,
	input  wire logic [7:0]   i_rd_addr,
	output logic      [7:0]   o_rd_data
);
	logic [7:0] mem [DEPTH];
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	assign wr_idx = res.addr - `AES_RES_BASE;
	assign rd_idx = i_rd_addr - `AES_RES_BASE;
	always_ff @(posedge i_core_clk) begin
		if (res.wr && wr_idx < 8'(DEPTH)) begin
			mem[wr_idx[$clog2(DEPTH)-1:0]] <= res.data;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_data <= 8'h00;
		end else if (rd_idx < 8'(DEPTH)) begin
			o_rd_data <= mem[rd_idx[$clog2(DEPTH)-1:0]];
		end else begin
			o_rd_data <= 8'h00;
		end
	end
endmodule

// ---- hdl/aes_scanner.sv ----
// eight channel multiplexed digit converter scanner, top level
`timescale 1ns/100ps
`include "aes_defines.svh"
module aes_scanner #(
	parameter int NUM_CH = `AES_NUM_CH
) (
	input  wire logic            i_core_clk,
	input  wire logic            i_rst_b,
	input  wire logic            i_cs,
	input  wire logic [1:0]      i_rs,
	input  wire logic            i_wr,
	input  wire logic            i_rd,
	input  wire aes_pkg::aes_byte_t i_wdata,
	output aes_pkg::aes_byte_t   o_rdata,
	input  wire logic            i_scan_start,
	output logic                 o_scan_busy,
	output logic                 o_scan_done,
	output logic                 o_eoc_irq,
	output aes_pkg::aes_byte_t   o_channel_port_data,
	output aes_pkg::aes_byte_t   o_channel_port_oe,
	input  wire aes_pkg::aes_byte_t i_input_port_data,
	input  wire logic            i_port_b_ctrl_line_one,
	output logic                 o_port_b_ctrl_line_two,
	input  wire logic [7:0]      i_res_addr,
	output aes_pkg::aes_byte_t   o_res_data
);
	import aes_pkg::*;

	// ***********************************************
	// pin synchronisers
	// ***********************************************
	aes_byte_t  in_sync;
	logic       eoc_sync;
	aes_sync3 #(.W(8)) u_sync_in (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_async    (i_input_port_data),
		.o_sync     (in_sync)
	);
	aes_sync3 #(.W(1)) u_sync_eoc (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_async    (i_port_b_ctrl_line_one),
		.o_sync     (eoc_sync)
	);

	// ***********************************************
	// port registers
	// ***********************************************
	aes_byte_t  dir_a;
	aes_byte_t  dir_b;
	aes_byte_t  ctl_a;
	aes_byte_t  ctl_b;
	aes_byte_t  out_a;
	aes_byte_t  out_b;
	logic       sel_data_a;
	logic       sel_data_b;
	logic       wr_da;
	logic       wr_ca;
	logic       wr_db;
	logic       wr_cb;
	logic       rd_db;

	// arguments passed in so continuous assigns see every change
	function automatic logic acc_hit(input logic       cs,
	                                 input logic       en,
	                                 input logic [1:0] rs,
	                                 input logic [1:0] want);
		acc_hit = cs && en && (rs == want);
	endfunction

	// four locations from chip and register select
	assign wr_da = acc_hit(i_cs, i_wr, i_rs, `AES_RS_DATA_A);
	assign wr_ca = acc_hit(i_cs, i_wr, i_rs, `AES_RS_CTRL_A);
	assign wr_db = acc_hit(i_cs, i_wr, i_rs, `AES_RS_DATA_B);
	assign wr_cb = acc_hit(i_cs, i_wr, i_rs, `AES_RS_CTRL_B);
	assign rd_db = acc_hit(i_cs, i_rd, i_rs, `AES_RS_DATA_B);
	// control bit two steers shared address
	assign sel_data_a = ctl_a[`AES_CTRL_SEL_BIT];
	assign sel_data_b = ctl_b[`AES_CTRL_SEL_BIT];

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dir_a <= `AES_DDR_RST;
			dir_b <= `AES_DDR_RST;
			ctl_a <= `AES_CTRL_RST;
			ctl_b <= `AES_CTRL_RST;
			out_a <= 8'h00;
			out_b <= 8'h00;
		end else begin
			if (wr_ca) begin
				ctl_a <= i_wdata;
			end
			if (wr_cb) begin
				ctl_b <= i_wdata;
			end
			if (wr_da && !sel_data_a) begin
				dir_a <= i_wdata;
			end
			if (wr_da && sel_data_a) begin
				out_a <= i_wdata;
			end
			if (wr_db && !sel_data_b) begin
				dir_b <= i_wdata;
			end
			if (wr_db && sel_data_b) begin
				out_b <= i_wdata;
			end
		end
	end

	// ***********************************************
	// read path and pins
	// ***********************************************
	aes_byte_t  chan_code;
	aes_byte_t  pin_a;
	aes_byte_t  pin_b;
	aes_byte_t  next_rdata;
	logic       irq_flag;
	// per-line direction; a side out, b side in
	assign pin_a = (dir_a & chan_code) | (~dir_a & 8'h00);
	assign pin_b = (dir_b & out_b) | (~dir_b & in_sync);
	always_comb begin
		next_rdata = 8'h00;
		case (i_rs)
			`AES_RS_DATA_A: next_rdata = sel_data_a ? pin_a : dir_a;
			`AES_RS_CTRL_A: next_rdata = ctl_a;
			`AES_RS_DATA_B: next_rdata = sel_data_b ? pin_b : dir_b;
			`AES_RS_CTRL_B: next_rdata = {irq_flag, ctl_b[6:0]};
			default:        next_rdata = 8'h00;
		endcase
	end
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 8'h00;
		end else if (i_cs && i_rd) begin
			o_rdata <= next_rdata;
		end
	end
	// 3-bit code on low lines; held per measurement
	// data and enable registered together so they never disagree
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_channel_port_data <= 8'h00;
			o_channel_port_oe   <= 8'h00;
		end else begin
			o_channel_port_data <= pin_a;
			o_channel_port_oe   <= dir_a;
		end
	end

	// ***********************************************
	// end of conversion event
	// ***********************************************
	logic eoc_prev;
	logic eoc_rise;
	assign eoc_rise = eoc_sync && !eoc_prev;
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			eoc_prev <= 1'b0;
			irq_flag <= 1'b0;
		end else begin
			eoc_prev <= eoc_sync;
			// event sets flag, set beats data read clear
			if (eoc_rise) begin
				irq_flag <= 1'b1;
			end else if (rd_db) begin
				irq_flag <= 1'b0;
			end
		end
	end
	assign o_eoc_irq = irq_flag;

	// ***********************************************
	// scan sequencer
	// ***********************************************
	aes_state_e state;
	aes_state_e next_state;
	logic [1:0] waits;
	logic [2:0] chan;
	logic [3:0] ptr;
	logic [1:0] dig;
	logic [3:0] msd;
	logic       strobe;
	logic       first;
	logic [3:0] sel_lines;
	logic [3:0] bcd;
	logic       hit;
	logic       ovr;
	aes_res_if  res ();

	// upper nibble selects, lower nibble bcd masked
	assign sel_lines = in_sync[7:4];
	assign bcd       = in_sync[3:0];
	// poll until pointer matches active select
	assign hit       = |(sel_lines & ptr);
	// over-range test on stored msd; coding
	assign ovr       = (msd & `AES_OVR_MASK) == `AES_OVR_MATCH;

	function automatic aes_byte_t fix_msd(input logic [3:0] m);
		// half digit to lsb, negative flag to msb
		fix_msd = {~m[2], 6'h00, ~m[3]};
	endfunction

	function automatic logic [7:0] word_addr(input logic [2:0] c,
	                                         input logic [1:0] d);
		// base 0010; four words, msd first
		word_addr = `AES_RES_BASE + {3'h0, c, d};
	endfunction

	always_comb begin
		next_state = state;
		case (state)
			AES_IDLE:  if (i_scan_start) next_state = AES_ARM;
			AES_ARM:   next_state = AES_WAIT;
			AES_WAIT:  if (eoc_rise && waits == 2'h1) begin
					next_state = AES_DIGIT;
				end
			AES_DIGIT: if (hit && dig == 2'h3) next_state = AES_FIX;
			AES_FIX:   next_state = AES_NEXT;
			AES_NEXT:  next_state = (chan == 3'(NUM_CH - 1)) ?
				AES_IDLE : AES_ARM;
			default:   next_state = AES_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= AES_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			waits  <= 2'h0;
			chan   <= 3'h0;
			ptr    <= `AES_PTR_START;
			dig    <= 2'h0;
			msd    <= 4'h0;
			strobe <= 1'b0;
			first  <= 1'b1;
		end else begin
			case (state)
				AES_IDLE: begin
					chan  <= 3'h0;
					first <= 1'b1;
				end
				AES_ARM: begin
					// three waits first channel, two after
					waits  <= first ? `AES_FIRST_WAITS
					                : `AES_LATER_WAITS;
					ptr    <= `AES_PTR_START;
					dig    <= 2'h0;
					strobe <= 1'b0;
				end
				AES_WAIT: begin
					if (eoc_rise) begin
						waits <= waits - 2'h1;
					end
					if (eoc_rise && waits == 2'h2) begin
						strobe <= 1'b1;
					end
				end
				AES_DIGIT: begin
					// lower strobe after end of conversion
					strobe <= 1'b0;
					if (hit) begin
						ptr <= {ptr[2:0], 1'b0};
						dig <= dig + 2'h1;
						if (dig == 2'h0) begin
							msd <= bcd;
						end
					end
				end
				AES_NEXT: begin
					first <= 1'b0;
					if (chan != 3'(NUM_CH - 1)) begin
						chan <= chan + 3'h1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	assign o_port_b_ctrl_line_two = strobe;
	assign chan_code = {5'h00, chan};
	assign o_scan_busy = (state != AES_IDLE);
	// scan length follows converter rate, not timed here
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_scan_done <= 1'b0;
		end else begin
			o_scan_done <= (state == AES_NEXT) &&
			               (chan == 3'(NUM_CH - 1));
		end
	end

	// ***********************************************
	// result writes
	// ***********************************************
	assign res.wr   = (state == AES_DIGIT && hit) || (state == AES_FIX);
	assign res.addr = (state == AES_FIX) ? word_addr(chan, 2'h0)
	                                     : word_addr(chan, dig);
	assign res.data = (state == AES_FIX) ?
		(ovr ? `AES_OVR_CODE : fix_msd(msd)) : {4'h0, bcd};

	aes_store #(.DEPTH(4 * NUM_CH)) u_store (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.res        (res),
		.i_rd_addr  (i_res_addr),
		.o_rd_data  (o_res_data)
	);
endmodule

// ---- tb/aes_conv_model.sv ----
// behavioural converter with channel selector, far side of the scanner
`timescale 1ns/100ps
module aes_conv_model (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_b,
	input  wire logic [7:0]   i_chan,
	input  wire logic         i_strobe,
	input  wire logic [127:0] i_digits,
	output logic      [7:0]   o_pins,
	output logic              o_eoc
);
	logic [6:0] cnt;
	logic [5:0] ph;
	logic [1:0] sl;
	logic [2:0] prev;
	logic [2:0] lat;
	logic [3:0] m;
	logic [3:0] last;
	logic       pol;
	logic       seen;
	logic       stb_q;
	logic       act;
	assign ph = 6'(cnt - 7'h08);
	assign sl = ph[5:4];
	assign act = cnt >= 7'h08 && cnt < 7'h48 && ph[3:0] < 4'hC;
	// sign wrong until a settled cycle
	assign m = i_digits[{lat, sl, 2'h0} +: 4] ^
	           {1'b0, !pol && sl == 2'h0, 2'h0};
	assign o_eoc = cnt < 7'h02;
	assign o_pins = act ? {4'h1 << sl, m} : {4'h0, ~last};
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt <= 7'h00;
			prev <= 3'h0;
			lat <= 3'h0;
			pol <= 1'b0;
			seen <= 1'b0;
			stb_q <= 1'b0;
			last <= 4'h0;
		end else begin
			cnt <= (cnt == 7'h4F) ? 7'h00 : cnt + 7'h01;
			stb_q <= i_strobe;
			last <= o_pins[3:0];
			// latch needs an earlier strobe edge
			if (i_strobe && !stb_q)
				seen <= 1'b1;
			if (cnt == 7'h00) begin
				seen <= 1'b0;
				prev <= i_chan[2:0];
				if (seen) begin
					lat <= i_chan[2:0];
					pol <= prev == i_chan[2:0];
				end
			end
		end
	end
endmodule

// ---- tb/aes_scanner_asserts.sv ----
// port checks for the scanner top
`timescale 1ns/100ps
module aes_scanner_asserts (
	input wire logic               i_core_clk,
	input wire logic               i_rst_b,
	input wire logic               i_scan_start,
	input wire logic               o_scan_busy,
	input wire logic               o_scan_done,
	input wire logic               o_eoc_irq,
	input wire aes_pkg::aes_byte_t o_channel_port_data,
	input wire aes_pkg::aes_byte_t o_channel_port_oe,
	input wire logic               i_port_b_ctrl_line_one,
	input wire logic               o_port_b_ctrl_line_two,
	input wire logic [7:0]         i_res_addr,
	input wire aes_pkg::aes_byte_t o_res_data
);
	import aes_pkg::*;
	logic in_rng;
	assign in_rng = i_res_addr >= 8'h10 && i_res_addr <= 8'h2F;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	a_port_dir_mask: assert property (
		(o_channel_port_data & ~(o_channel_port_oe & 8'h07)) == 8'h00)
		else $error("channel line driven while input");
	a_chan_between: assert property (
		$changed(o_channel_port_data) && o_scan_busy
		|-> !o_port_b_ctrl_line_two) else $error("channel moved in measure");
	a_start_taken: assert property (
		i_scan_start && !o_scan_busy |=> o_scan_busy)
		else $error("start not taken");
	a_done_single: assert property (o_scan_done |=> !o_scan_done)
		else $error("done longer than one cycle");
	a_irq_after_eoc: assert property (
		$rose(i_port_b_ctrl_line_one) |-> ##[2:6] o_eoc_irq)
		else $error("no interrupt after end pulse");
	a_strobe_in_scan: assert property (
		$rose(o_port_b_ctrl_line_two) |-> o_scan_busy)
		else $error("strobe outside scan");
	a_res_outside: assert property (!in_rng |=> o_res_data == 8'h00)
		else $error("data outside result area");
	a_digit_nibble: assert property (
		in_rng && i_res_addr[1:0] != 2'h0 |=> o_res_data[7:4] == 4'h0)
		else $error("digit word upper bits set");
	a_msd_code: assert property (
		in_rng && i_res_addr[1:0] == 2'h0
		|=> o_res_data == 8'hF1 || (o_res_data & 8'h7E) == 8'h00)
		else $error("bad leading word");
	c_scan_done: cover property (o_scan_done);
	c_overrange: cover property (in_rng && o_res_data == 8'hF1);
	c_irq: cover property ($rose(o_eoc_irq));
endmodule
bind aes_scanner aes_scanner_asserts i_aes_scanner_asserts (.i_core_clk,
	.i_rst_b, .i_scan_start, .o_scan_busy, .o_scan_done, .o_eoc_irq,
	.o_channel_port_data, .o_channel_port_oe, .i_port_b_ctrl_line_one,
	.o_port_b_ctrl_line_two, .i_res_addr, .o_res_data);

// ---- tb/aes_scanner_test.sv ----
// scanner testbench with converter model
`timescale 1ns/100ps
module aes_scanner_test;
	import aes_pkg::*;
	logic i_core_clk, i_rst_b, i_cs, i_wr, i_rd, i_scan_start;
	logic [1:0] i_rs;
	aes_byte_t i_wdata, o_rdata, o_channel_port_data, o_channel_port_oe;
	aes_byte_t i_input_port_data, i_res_addr, o_res_data, r;
	logic o_scan_busy, o_scan_done, o_eoc_irq;
	logic i_port_b_ctrl_line_one, o_port_b_ctrl_line_two;
	logic [127:0] dig;
	int bad_count, samples_checked, i, c;
	aes_scanner i_aes_scanner (.i_core_clk, .i_rst_b, .i_cs, .i_rs, .i_wr,
		.i_rd, .i_wdata, .o_rdata, .i_scan_start, .o_scan_busy, .o_scan_done,
		.o_eoc_irq, .o_channel_port_data, .o_channel_port_oe,
		.i_input_port_data, .i_port_b_ctrl_line_one, .o_port_b_ctrl_line_two,
		.i_res_addr, .o_res_data);
	aes_conv_model i_aes_conv_model (.i_core_clk, .i_rst_b,
		.i_chan(o_channel_port_data), .i_strobe(o_port_b_ctrl_line_two),
		.i_digits(dig), .o_pins(i_input_port_data),
		.o_eoc(i_port_b_ctrl_line_one));
	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end
	task automatic chk(input aes_byte_t got, input aes_byte_t exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc;
		@(posedge i_core_clk);
		#2;
	endtask
	task automatic acc(input logic [1:0] a, input logic w, input aes_byte_t d);
		i_cs = 1'b1;
		i_rs = a;
		i_wr = w;
		i_rd = !w;
		i_wdata = d;
		cyc;
		i_cs = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		cyc;
	endtask
	function automatic aes_byte_t exp_word(input logic [3:0] v, input logic msd);
		if (!msd)
			return {4'h0, v};
		if ((v & 4'hB) == 4'h3)
			return 8'hF1;
		return {~v[2], 6'h00, ~v[3]};
	endfunction
	task automatic give_verdict;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		{i_rst_b, i_cs, i_wr, i_rd, i_scan_start} = 5'h00;
		i_rs = 2'h0;
		i_wdata = 8'h00;
		i_res_addr = 8'h00;
		dig = '0;
		bad_count = 0;
		samples_checked = 0;
		r = 8'($urandom(32'h233F3456));
		repeat (4) @(posedge i_core_clk);
		#2 i_rst_b = 1'b1;
		r = 8'($urandom);
		acc(2'h0, 1'b1, r);
		acc(2'h0, 1'b0, 8'h00);
		chk(o_rdata, r);
		chk(o_channel_port_oe, r);
		chk(o_channel_port_data, 8'h00);
		$display("test directions done");
		acc(2'h0, 1'b1, 8'hFF);
		acc(2'h2, 1'b1, 8'h00);
		acc(2'h1, 1'b1, 8'h34);
		acc(2'h3, 1'b1, 8'h34);
		acc(2'h1, 1'b0, 8'h00);
		chk(o_rdata, 8'h34);
		chk(o_channel_port_oe, 8'hFF);
		$display("test setup done");
		acc(2'h2, 1'b0, 8'h00);
		chk({7'h00, o_eoc_irq}, 8'h00);
		for (c = 0; c < 200 && o_eoc_irq !== 1'b1; c++)
			cyc;
		chk({7'h00, o_eoc_irq}, 8'h01);
		acc(2'h3, 1'b0, 8'h00);
		chk(o_rdata, 8'hB4);
		acc(2'h2, 1'b0, 8'h00);
		acc(2'h3, 1'b0, 8'h00);
		chk(o_rdata, 8'h34);
		$display("test interrupt done");
		for (int s = 0; s < 2; s++) begin
			for (i = 0; i < 128; i += 4)
				dig[i +: 4] = i[3:2] == 2'h0 ? 4'($urandom) : 4'($urandom % 10);
			if (s == 0) begin
				dig[19:16] = 4'h3;
				dig[51:48] = 4'h0;
				dig[99:96] = 4'h7;
			end
			i_scan_start = 1'b1;
			repeat (3) cyc;
			i_scan_start = 1'b0;
			chk({7'h00, o_scan_busy}, 8'h01);
			for (c = 0; c < 4000 && o_scan_done !== 1'b1; c++)
				cyc;
			if (c == 4000) begin
				bad_count++;
				$display("[FAIL] %0t scan never finished", $time);
				give_verdict;
			end
			for (i = 0; i < 32; i++) begin
				i_res_addr = 8'h10 + 8'(i);
				cyc;
				chk(o_res_data, exp_word(dig[i*4 +: 4], i[1:0] == 2'h0));
			end
			i_res_addr = 8'h30;
			cyc;
			chk(o_res_data, 8'h00);
			chk({7'h00, o_scan_busy}, 8'h00);
			chk({7'h00, o_port_b_ctrl_line_two}, 8'h00);
			chk(o_channel_port_data, 8'h00);
			i_res_addr = 8'h00;
			$display("test scan %0d done", s);
		end
		give_verdict;
	end
endmodule
